// >>> core/imu_ctrl_pkg.sv
// Shared constants and types for the filter and serial output control block
package imu_ctrl_pkg;
  // Register byte addresses and widths
  localparam logic [7:0] ADDR_FILTER_CONTROL = 8'h06;
  localparam logic [7:0] ADDR_SERIAL_OUTPUT_CONTROL = 8'h08;
  localparam int REG_W = 16;
  // Field positions
  localparam int FILT_SEL_LSB = 0;
  localparam int FILT_SEL_W = 5;
  localparam int FILT_BUSY_BIT = 5;
  localparam int STREAM_BIT = 0;
  localparam int AUTOSTART_BIT = 1;
  localparam int BAUD_LSB = 8;
  localparam int BAUD_W = 2;
  // Packet content bits that carry delta angle and delta velocity
  localparam int DLTA_BIT = 11;
  localparam int DLTV_BIT = 10;
  // Reset values
  localparam logic [4:0] FILT_SEL_RST = 5'h00;
  localparam logic [1:0] BAUD_RST = 2'h0;
  // Rate code of the fastest sample rate, 2000 samples per second
  localparam logic [7:0] RATE_FASTEST = 8'h00;
  // Marker shown on sensor outputs during a bad rate and filter combination
  localparam logic [15:0] SENSOR_MARKER = 16'h7EF0;
  localparam int SENSOR_N = 7;
  // Filter code boundaries
  localparam logic [1:0] FIR_GROUP = 2'h1;
  localparam logic [2:0] FIR128_GROUP = 3'h4;
  localparam logic [7:0] TAPS_FIR_SHORT = 8'h20;
  localparam logic [7:0] TAPS_FIR_MID = 8'h40;
  localparam logic [7:0] TAPS_FIR_LONG = 8'h80;
  // Timing at a 40 MHz clock
  localparam int CLK_MHZ = 40;
  localparam int FILT_SET_TIME_US = 10;
  localparam int FILT_SET_CYC = FILT_SET_TIME_US * CLK_MHZ;
  localparam int INIT_TIME_US = 800;
  localparam int INIT_CYC = INIT_TIME_US * CLK_MHZ;
  // Baud codes
  typedef enum logic [1:0] {
    BAUD_460K8 = 2'h0,
    BAUD_230K4 = 2'h1,
    BAUD_921K6 = 2'h2
  } baud_t;
  // Settings restored from nonvolatile storage after reset
  typedef struct packed {
    logic [4:0] filt_sel;
    logic [1:0] baud;
    logic autostart;
    logic stream;
  } saved_cfg_t;
  // One transmit request: stream packet or read reply
  typedef struct packed {
    logic reply;
    logic [15:0] content;
    logic [15:0] width;
    logic [15:0] data;
  } tx_req_t;
endpackage

// >>> core/imu_output_ctrl.sv
// Filter selection, serial rate and streaming control with transmit buffer
`timescale 1ns/1ps
module imu_output_ctrl #(
  parameter int INIT_CYCLES = imu_ctrl_pkg::INIT_CYC,
  parameter int BUSY_CYCLES = imu_ctrl_pkg::FILT_SET_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register access port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_q,
  // Neighbouring settings and restored configuration
  input wire imu_ctrl_pkg::saved_cfg_t saved_cfg,
  input wire logic [7:0] sample_rate_control,
  input wire logic [15:0] packet_content_select,
  input wire logic [15:0] packet_width_select,
  input wire logic sample_tick,
  // Host read command in manual mode
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_addr,
  output logic cmd_ready_q,
  // Transmit request stream
  output imu_ctrl_pkg::tx_req_t tx_q,
  output logic tx_valid_q,
  input wire logic tx_ready,
  // Filter decode, rate and sensor outputs
  output logic filt_fir_q,
  output logic [7:0] filt_taps_q,
  output logic [1:0] filt_cutoff_q,
  output logic [1:0] baud_q,
  output logic delta_ok_q,
  input wire logic set_err,
  input wire logic [6:0][15:0] sensor_in,
  output logic [6:0][15:0] sensor_q
);
  import imu_ctrl_pkg::*;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_IDLE = 2'b01,
    ST_STREAM = 2'b11
  } state_t;
  localparam int CNT_W = $clog2(INIT_CYCLES + BUSY_CYCLES + 1);
  localparam int BUSY_MAX = BUSY_CYCLES;

  state_t st_q, st_d;
  logic [CNT_W-1:0] init_cnt_q, init_cnt_d, busy_cnt_q, busy_cnt_d;
  logic [4:0] filt_sel_q, filt_sel_d;
  logic busy_q, busy_d, stream_q, stream_d, start_q, start_d;
  logic [1:0] baud_d;
  logic fir_d, delta_ok_d, ready_d;
  logic [7:0] taps_d;
  logic [1:0] cutoff_d;
  logic [15:0] rdata_d;
  logic [6:0][15:0] sensor_d;
  tx_req_t s0_q, s0_d, s1_q, s1_d, in_req;
  logic [1:0] cnt_q, cnt_d;
  logic valid_d, pend_q, pend_d, push, pop, wr_filt, wr_uart, live;

  // Register read view; shared by the port and by read replies
  function automatic logic [15:0] rd_word(input logic [7:0] a);
    logic [15:0] w;
    w = '0;
    if (a == ADDR_FILTER_CONTROL) begin
      w[FILT_SEL_LSB +: FILT_SEL_W] = filt_sel_q;
      w[FILT_BUSY_BIT] = busy_q;
    end else if (a == ADDR_SERIAL_OUTPUT_CONTROL) begin
      w[BAUD_LSB +: BAUD_W] = baud_q;
      w[AUTOSTART_BIT] = start_q;
      w[STREAM_BIT] = stream_q;
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and sequencing
  // Access during initialisation is ignored; restored values would win
  assign live = (st_q != ST_INIT);
  assign wr_filt = live && reg_wr && (reg_addr == ADDR_FILTER_CONTROL);
  assign wr_uart = live && reg_wr && (reg_addr == ADDR_SERIAL_OUTPUT_CONTROL);

  always_comb begin
    st_d = st_q;
    init_cnt_d = init_cnt_q;
    filt_sel_d = filt_sel_q;
    stream_d = stream_q;
    start_d = start_q;
    baud_d = baud_q;
    busy_d = busy_q;
    busy_cnt_d = busy_cnt_q;
    unique case (st_q)
      ST_INIT: begin
        init_cnt_d = init_cnt_q + 1'b1;
        if (init_cnt_q == CNT_W'(INIT_CYCLES - 1)) begin
          filt_sel_d = saved_cfg.filt_sel;
          baud_d = saved_cfg.baud;
          stream_d = saved_cfg.stream;
          start_d = saved_cfg.autostart;
          // Autostart alone does nothing without streaming
          st_d = (saved_cfg.stream && saved_cfg.autostart) ?
                 ST_STREAM : ST_IDLE;
        end
      end
      ST_IDLE: if (stream_q) st_d = ST_STREAM;
      ST_STREAM: if (!stream_q) st_d = ST_IDLE;
      default: st_d = ST_INIT;
    endcase
    // Busy ends on its own count; a fresh write restarts it
    if (busy_q) begin
      busy_cnt_d = busy_cnt_q + 1'b1;
      if (busy_cnt_q == CNT_W'(BUSY_CYCLES - 1)) busy_d = 1'b0;
    end
    if (wr_filt) begin
      filt_sel_d = reg_wdata[FILT_SEL_LSB +: FILT_SEL_W];
      busy_d = 1'b1;
      busy_cnt_d = '0;
    end
    if (wr_uart) begin
      baud_d = reg_wdata[BAUD_LSB +: BAUD_W];
      stream_d = reg_wdata[STREAM_BIT];
      start_d = reg_wdata[AUTOSTART_BIT];
    end
  end

  // Filter decode from the next selection so outputs track the register
  always_comb begin
    fir_d = 1'b0;
    taps_d = '0;
    cutoff_d = filt_sel_d[1:0];
    if (filt_sel_d[4:3] == 2'h0) begin
      cutoff_d = '0;
      if (filt_sel_d[2:0] != 3'h0) taps_d = 8'h01 << filt_sel_d[2:0];
    end else if (filt_sel_d[4:3] == FIR_GROUP) begin
      fir_d = 1'b1;
      taps_d = filt_sel_d[2] ? TAPS_FIR_MID : TAPS_FIR_SHORT;
    end else if (filt_sel_d[4:2] == FIR128_GROUP) begin
      fir_d = 1'b1;
      taps_d = TAPS_FIR_LONG;
    end else begin
      // Unused codes: no defined filter, reported as none
      cutoff_d = '0;
    end
  end

  // Register read, delta gating and sensor marker
  always_comb begin
    rdata_d = (live && reg_rd) ? rd_word(reg_addr) : '0;
    delta_ok_d = (sample_rate_control != RATE_FASTEST);
    for (int i = 0; i < SENSOR_N; i++) begin
      sensor_d[i] = set_err ? SENSOR_MARKER : sensor_in[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= ST_INIT;
      init_cnt_q <= '0;
      busy_cnt_q <= '0;
      filt_sel_q <= FILT_SEL_RST;
      busy_q <= 1'b0;
      stream_q <= 1'b0;
      start_q <= 1'b0;
      baud_q <= BAUD_RST;
      filt_fir_q <= 1'b0;
      filt_taps_q <= '0;
      filt_cutoff_q <= '0;
      reg_rdata_q <= '0;
      delta_ok_q <= 1'b0;
      sensor_q <= '0;
    end else begin
      st_q <= st_d;
      init_cnt_q <= init_cnt_d;
      busy_cnt_q <= busy_cnt_d;
      filt_sel_q <= filt_sel_d;
      busy_q <= busy_d;
      stream_q <= stream_d;
      start_q <= start_d;
      baud_q <= baud_d;
      filt_fir_q <= fir_d;
      filt_taps_q <= taps_d;
      filt_cutoff_q <= cutoff_d;
      reg_rdata_q <= rdata_d;
      delta_ok_q <= delta_ok_d;
      sensor_q <= sensor_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry transmit buffer; a held tick waits rather than being lost
  always_comb begin
    pend_d = pend_q;
    in_req = '0;
    push = 1'b0;
    if (st_q == ST_STREAM && sample_tick) pend_d = 1'b1;
    if (st_q != ST_STREAM) pend_d = 1'b0;
    if (st_q == ST_STREAM) begin
      in_req.content = packet_content_select;
      in_req.width = packet_width_select;
      if (sample_rate_control == RATE_FASTEST) begin
        in_req.content[DLTA_BIT] = 1'b0;
        in_req.content[DLTV_BIT] = 1'b0;
      end
      push = pend_q && (cnt_q != 2'h2);
      if (push) pend_d = sample_tick;
    end else if (cmd_valid && cmd_ready_q) begin
      in_req.reply = 1'b1;
      in_req.data = rd_word(cmd_addr);
      push = 1'b1;
    end
    pop = tx_valid_q && tx_ready;
    s0_d = s0_q;
    s1_d = s1_q;
    cnt_d = cnt_q;
    unique case (cnt_q)
      2'h0: if (push) begin
        s0_d = in_req;
        cnt_d = 2'h1;
      end
      2'h1: begin
        if (pop && push) s0_d = in_req;
        else if (push) begin
          s1_d = in_req;
          cnt_d = 2'h2;
        end else if (pop) cnt_d = 2'h0;
      end
      2'h2: if (pop) begin
        s0_d = s1_q;
        cnt_d = 2'h1;
      end
      default: cnt_d = 2'h0;
    endcase
    valid_d = (cnt_d != 2'h0);
    // Replies are taken only in manual mode and with a free slot
    ready_d = live && (cnt_d != 2'h2) && (st_d != ST_STREAM);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s0_q <= '0;
      s1_q <= '0;
      cnt_q <= '0;
      pend_q <= 1'b0;
      tx_valid_q <= 1'b0;
      cmd_ready_q <= 1'b0;
    end else begin
      s0_q <= s0_d;
      s1_q <= s1_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      tx_valid_q <= valid_d;
      cmd_ready_q <= ready_d;
    end
  end
  assign tx_q = s0_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_busy_rises: assert property (wr_filt |=> busy_q)
    else $error("filter busy not raised after write");
  chk_busy_settles: assert property ($rose(busy_q) |-> ##[1:BUSY_MAX] !busy_q)
    else $error("filter busy did not clear in time");
  chk_moving_taps: assert property (filt_sel_q[4:3] == 2'h0 |-> !filt_fir_q
    && filt_taps_q == ((filt_sel_q[2:0] == 3'h0) ? 8'h00
    : 8'h01 << filt_sel_q[2:0]))
    else $error("moving average taps wrong");
  chk_fir_short: assert property (filt_sel_q[4:3] == 2'h1 |-> filt_fir_q
    && filt_taps_q == (filt_sel_q[2] ? 8'h40 : 8'h20)
    && filt_cutoff_q == filt_sel_q[1:0])
    else $error("windowed filter decode wrong");
  chk_fir_long: assert property (filt_sel_q[4:2] == 3'h4 |-> filt_fir_q
    && filt_taps_q == 8'h80 && filt_cutoff_q == filt_sel_q[1:0])
    else $error("long windowed filter decode wrong");
  chk_rate_apply: assert property (wr_uart |=> baud_q == $past(reg_wdata[9:8]))
    else $error("serial rate not applied after write");
  chk_marker_out: assert property (set_err |=> sensor_q[0] == 16'h7EF0
    && sensor_q[6] == 16'h7EF0)
    else $error("sensor marker missing");
  chk_delta_gate: assert property (push && !in_req.reply
    && sample_rate_control == 8'h00 |-> in_req.content[11:10] == 2'h0)
    else $error("delta output at fastest rate");
  // Empty buffer outside streaming stays empty unless a command is taken
  chk_manual_quiet: assert property (cnt_q == 2'h0 && st_q != ST_STREAM
    && !(cmd_valid && cmd_ready_q) |=> !tx_valid_q)
    else $error("word sent in manual mode without a command");
  chk_init_start: assert property (st_q == ST_INIT && st_d != ST_INIT
    && !(saved_cfg.stream && saved_cfg.autostart) |=> st_q == ST_IDLE)
    else $error("streamed at start without both bits");

  cov_stream_pkt: cover property (st_q == ST_STREAM ##1 tx_valid_q && tx_ready);
  cov_reply: cover property (cmd_valid && cmd_ready_q ##[1:3] tx_valid_q);
  cov_buf_full: cover property (cnt_q == 2'h2 && !tx_ready);
  cov_filt_done: cover property ($fell(busy_q));
endmodule // imu_output_ctrl

// >>> verif/host_model.sv
// Host-side model that pops transmit words, able to stall
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic clk_sys,
  // Transmit stream from the block
  input wire imu_ctrl_pkg::tx_req_t tx_q,
  input wire logic tx_valid_q,
  output logic tx_ready = 1'b0,
  // Bench control and observation
  input wire logic stall,
  output imu_ctrl_pkg::tx_req_t last_q = '0,
  output int pops = 0
);
  import imu_ctrl_pkg::*;
  // Word taken at the edge; ready moves just after it
  always @(posedge clk_sys) begin
    if (tx_valid_q && tx_ready) begin
      last_q <= tx_q;
      pops <= pops + 1;
    end
    tx_ready <= #1 !stall;
  end
endmodule // host_model

// >>> verif/tb_imu_output_ctrl.sv
// Self-checking bench for the filter and serial output control block
`timescale 1ns/1ps
module tb_imu_output_ctrl;
  import imu_ctrl_pkg::*;
  logic clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, sample_tick = 0;
  logic cmd_valid = 0, set_err = 0, stall = 0, tx_valid_q, tx_ready;
  logic cmd_ready_q, filt_fir_q, delta_ok_q;
  logic [7:0] reg_addr = 0, sample_rate_control = 0, cmd_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata_q, packet_content_select = 0;
  logic [15:0] packet_width_select = 0;
  logic [7:0] filt_taps_q;
  logic [1:0] filt_cutoff_q, baud_q;
  logic [6:0][15:0] sensor_in = '0, sensor_q;
  saved_cfg_t saved_cfg = {5'h03, 2'h1, 1'b1, 1'b0};
  tx_req_t tx_q, last_q;
  logic [15:0] v;
  int pops, n_fail = 0, checks_done = 0, cyc_n = 0;
  ////////////////////////////////////////////////////////////////////////
  // Short counts keep init and busy waits brief
  imu_output_ctrl #(.INIT_CYCLES(8), .BUSY_CYCLES(4)) i_imu_output_ctrl (
    .clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .saved_cfg(saved_cfg), .sample_rate_control(sample_rate_control),
    .packet_content_select(packet_content_select),
    .packet_width_select(packet_width_select), .sample_tick(sample_tick),
    .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_ready_q(cmd_ready_q),
    .tx_q(tx_q), .tx_valid_q(tx_valid_q), .tx_ready(tx_ready),
    .filt_fir_q(filt_fir_q), .filt_taps_q(filt_taps_q),
    .filt_cutoff_q(filt_cutoff_q), .baud_q(baud_q),
    .delta_ok_q(delta_ok_q), .set_err(set_err), .sensor_in(sensor_in),
    .sensor_q(sensor_q));
  host_model i_host_model (.clk_sys(clk_sys), .tx_q(tx_q),
    .tx_valid_q(tx_valid_q), .tx_ready(tx_ready), .stall(stall),
    .last_q(last_q), .pops(pops));
  ////////////////////////////////////////////////////////////////////////
  // 40 MHz clock and a cycle ceiling against hangs
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc_n++;
    if (cyc_n == 4000) begin
      n_fail++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Helpers; inputs always move 1 ns after an edge
  task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    cyc(1);
    reg_wr = 0;
    // Idle edge so a following call never re-drives the strobe at once
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr = a;
    reg_rd = 1;
    cyc(1);
    reg_rd = 0;
    d = reg_rdata_q;
    cyc(1);
  endtask
  task automatic tick();
    sample_tick = 1;
    cyc(1);
    sample_tick = 0;
  endtask
  task automatic wait_pop(input int n);
    for (int k = 0; k < 40 && pops < n; k++) cyc(1);
    chk(pops, n);
  endtask
  task automatic do_reset();
    reset = 1;
    cyc(3);
    reset = 0;
    cyc(12);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Restored settings; start-up flag alone starts nothing
  task automatic t_restore();
    rd(ADDR_FILTER_CONTROL, v);
    chk(v & 16'h001F, 16'h0003);
    chk(filt_taps_q, 8'h08);
    rd(ADDR_SERIAL_OUTPUT_CONTROL, v);
    chk(v, 16'h0102);
    rd(8'h0A, v);
    chk(v, 16'h0000);
    tick();
    cyc(6);
    chk({tx_valid_q, 32'(pops)}, 33'h0);
  endtask
  // Every defined filter code, busy raised then cleared
  task automatic t_filters();
    logic [7:0] taps;
    for (int c = 0; c < 20; c++) begin
      wr(ADDR_FILTER_CONTROL, 16'h0020 | c[15:0]);
      taps = c < 8 ? (c == 0 ? 8'h00 : 8'h01 << c) :
        c < 12 ? 8'h20 : c < 16 ? 8'h40 : 8'h80;
      chk({filt_fir_q, filt_taps_q, c > 7 ? filt_cutoff_q : 2'h0},
        {c > 7, taps, c > 7 ? c[1:0] : 2'h0});
      rd(ADDR_FILTER_CONTROL, v);
      chk(v, 16'h0020 | c[15:0]);
      for (int k = 0; k < 12 && v[FILT_BUSY_BIT] !== 1'b0; k++)
        rd(ADDR_FILTER_CONTROL, v);
      chk(v, c[15:0]);
    end
  endtask
  // Rate codes take effect right after the write
  task automatic t_baud();
    for (int b = 2; b >= 0; b--) begin
      wr(ADDR_SERIAL_OUTPUT_CONTROL, 16'(b) << BAUD_LSB);
      chk(baud_q, b[1:0]);
    end
  endtask
  // Manual read command yields exactly one reply
  task automatic t_cmd();
    int n;
    n = pops;
    cmd_addr = ADDR_FILTER_CONTROL;
    cmd_valid = 1;
    for (int k = 0; k < 20 && cmd_ready_q !== 1'b1; k++) cyc(1);
    cyc(1);
    cmd_valid = 0;
    wait_pop(n + 1);
    chk({last_q.reply, last_q.data}, {1'b1, 16'h0013});
    tick();
    cyc(6);
    chk(pops, n + 1);
  endtask
  // Streaming with a stalled host at the fastest rate, then a slower rate and stop
  task automatic t_stream();
    int n;
    n = pops;
    packet_content_select = 16'hFC07;
    packet_width_select = 16'h7000;
    stall = 1;
    wr(ADDR_SERIAL_OUTPUT_CONTROL, 16'h0001);
    chk(delta_ok_q, 1'b0);
    repeat (3) begin
      tick();
      cyc(3);
    end
    chk({tx_valid_q, tx_q.reply, tx_q.content, tx_q.width},
      {2'b10, 16'hF007, 16'h7000});
    chk(cmd_ready_q, 1'b0);
    stall = 0;
    wait_pop(n + 3);
    sample_rate_control = 8'h01;
    cyc(2);
    chk(delta_ok_q, 1'b1);
    tick();
    wait_pop(n + 4);
    chk(last_q.content, 16'hFC07);
    wr(ADDR_SERIAL_OUTPUT_CONTROL, 16'h0000);
    cyc(4);
    tick();
    cyc(6);
    chk(pops, n + 4);
  endtask
  // Marker value replaces sensor words during a bad combination
  task automatic t_sensor();
    for (int i = 0; i < SENSOR_N; i++) sensor_in[i] = 16'h1000 + 16'(i);
    cyc(2);
    chk(sensor_q, sensor_in);
    set_err = 1;
    cyc(2);
    chk(sensor_q, {SENSOR_N{SENSOR_MARKER}});
    set_err = 0;
  endtask
  // Both start-up bits restored: streams with no host request
  task automatic t_autostart();
    int n;
    wr(ADDR_SERIAL_OUTPUT_CONTROL, 16'h0103);
    saved_cfg = {5'h03, 2'h1, 1'b1, 1'b1};
    do_reset();
    n = pops;
    rd(ADDR_SERIAL_OUTPUT_CONTROL, v);
    chk(v, 16'h0103);
    tick();
    wait_pop(n + 1);
    chk(last_q.reply, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_reset();
    t_restore();
    t_filters();
    t_baud();
    t_cmd();
    t_stream();
    t_sensor();
    t_autostart();
    report_and_stop();
  end
endmodule // tb_imu_output_ctrl
